// file: rtl/hostport_pkg.sv
package hostport_pkg;
  // ---------------------------------------------------------------
  // Widths and constants
  // ---------------------------------------------------------------
  localparam int unsigned DATA_W = 16;
  localparam int unsigned ADDR_W = 24;
  localparam int unsigned REG_AW = 8; // Register address width
  localparam logic [15:0] DATA_RST = 16'h0000; // Output data after reset
  localparam logic [23:0] ADDR_RST = 24'h000000; // Output address after reset
  // Synced control pins after reset: deselected, strobes inactive
  localparam logic [7:0] PIN_IDLE = 8'h9e;
  localparam logic [3:0] LANE_IDLE = 4'hf; // Lane pins after reset, inactive

  // Bus styles selected by the static style pin
  typedef enum logic {
    STYLE_SEP_STROBE = 1'b0, // Separate read and write strobes
    STYLE_DATA_STROBE = 1'b1 // Data strobe with read/write line
  } bus_style_t;

  // Slave access request to the register file
  typedef struct packed {
    logic rd;              // One-cycle read pulse
    logic wr;              // One-cycle write pulse
    logic [7:0] addr;      // Byte address of the access
    logic lane_lo;         // Low byte lane active
    logic lane_hi;         // High byte lane active
    logic [15:0] wdata;    // Write data
  } reg_req_t;

  // Master address request from the DMA engine
  typedef struct packed {
    logic own;             // DMA owns the bus
    logic drive;           // Address phase active
    logic [23:0] addr;     // Destination address
    logic lane_lo;         // Low byte lane used
    logic lane_hi;         // High byte lane used
  } dma_req_t;
endpackage : hostport_pkg

// file: rtl/demux_host_bus_port.sv
`timescale 1ns/1ps
// How it works
// - Drive data lines only when supplying data
// - Decode host address to pick register
// - Drive DMA destination address when granted
// - Address outputs released unless driving address
// - Lowest address pin is address bit zero on the narrow bus only
// - Low byte enable marks low lane transfer
// - Upper strobe active low, released when idle
// - No interrupt acknowledge cycles supported
// - No multiplexed address/data bus
// - High byte enable marks high lane transfer
module demux_host_bus_port import hostport_pkg::*; (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic clk_en,
  // Host-side pins
  input wire logic chip_sel_n,
  input wire logic bus_style_select,
  input wire logic bus_width,
  input wire logic rd_n_in,
  input wire logic wr_n_in,
  input wire logic rw_in,
  input wire logic ds_n_in,
  input wire logic [23:0] addr_in,
  input wire logic lowest_address_line,
  input wire logic low_byte_enable,
  input wire logic high_byte_enable,
  input wire logic upper_byte_strobe,
  input wire logic lower_byte_strobe,
  input wire logic [15:0] data_in,
  output logic [15:0] data_out,
  output logic [15:0] data_oe,
  output logic [23:0] addr_out,
  output logic addr_oe,
  output logic upper_strobe_out,
  output logic upper_strobe_oe,
  // Register file side
  output reg_req_t reg_req,
  input wire logic [15:0] reg_rdata,
  // DMA side
  input wire dma_req_t dma_req
);
  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  localparam int unsigned SW = 8 + 24 + 16;
  logic [SW-1:0] s1_r, s2_r; // First stage read only by second
  logic [SW-1:0] pins;
  assign pins = {chip_sel_n, bus_style_select, bus_width, rd_n_in,
                 wr_n_in, rw_in, ds_n_in, lowest_address_line,
                 addr_in, data_in};

  // Two-flop capture of every asynchronous pin
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      // Idle pin levels, else a false strobe would follow reset
      s1_r <= {PIN_IDLE, ADDR_RST, DATA_RST};
      s2_r <= {PIN_IDLE, ADDR_RST, DATA_RST};
    end else if (clk_en) begin
      s1_r <= pins;
      s2_r <= s1_r;
    end
  end

  logic [3:0] lane_s1_r, lane_s2_r; // Lane pins, same treatment
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      lane_s1_r <= LANE_IDLE;
      lane_s2_r <= LANE_IDLE;
    end else if (clk_en) begin
      lane_s1_r <= {low_byte_enable, high_byte_enable,
                    lower_byte_strobe, upper_byte_strobe};
      lane_s2_r <= lane_s1_r;
    end
  end

  // Unpacked synchronised views
  logic cs_n_s, style_s, width_s, rd_n_s, wr_n_s, rw_s, ds_n_s, a0_s;
  logic [23:0] addr_s;
  logic [15:0] din_s;
  logic ble_n_s, bhe_n_s, lds_n_s, uds_n_s;
  assign {cs_n_s, style_s, width_s, rd_n_s, wr_n_s, rw_s, ds_n_s, a0_s,
          addr_s, din_s} = s2_r;
  assign {ble_n_s, bhe_n_s, lds_n_s, uds_n_s} = lane_s2_r;

  // ---------------------------------------------------------------
  // Access decode
  // ---------------------------------------------------------------
  logic sel, rd_act, wr_act, lane_lo, lane_hi, bit0;
  always_comb begin
    sel = !cs_n_s;
    // strobe style from static pin, no address latch
    if (bus_style_t'(style_s) == STYLE_DATA_STROBE) begin
      rd_act = sel && rw_s && (!ds_n_s || !lds_n_s || !uds_n_s);
      wr_act = sel && !rw_s && (!ds_n_s || !lds_n_s || !uds_n_s);
    end else begin
      rd_act = sel && !rd_n_s;
      wr_act = sel && !wr_n_s;
    end
    // width pin picks byte or word path
    if (!width_s) begin
      // lowest pin is address bit zero; one lane used
      bit0 = a0_s;
      lane_lo = 1'b1;
      lane_hi = 1'b0;
    end else if (bus_style_t'(style_s) == STYLE_DATA_STROBE) begin
      // strobes active low set the access type
      lane_lo = !lds_n_s;
      lane_hi = !uds_n_s;
      bit0 = lane_hi && !lane_lo;
    end else begin
      lane_lo = !ble_n_s;
      lane_hi = !bhe_n_s;
      bit0 = lane_hi && !lane_lo;
    end
  end

  // ---------------------------------------------------------------
  // Access state: pulse once per strobe
  // ---------------------------------------------------------------
  logic rd_seen_r, rd_seen_nxt, wr_seen_r, wr_seen_nxt;
  reg_req_t req_r, req_nxt;
  logic [15:0] dout_r, dout_nxt;
  logic [15:0] doe_r, doe_nxt;

  // Next-state for the slave path
  always_comb begin
    rd_seen_nxt = rd_act;
    wr_seen_nxt = wr_act;
    req_nxt = '0;
    // decoded address goes to the register file
    req_nxt.addr = {addr_s[7:1], bit0};
    req_nxt.lane_lo = lane_lo;
    req_nxt.lane_hi = lane_hi;
    // Narrow bus: byte rides on low data pins
    req_nxt.wdata = width_s ? din_s : {din_s[7:0], din_s[7:0]};
    req_nxt.rd = rd_act && !rd_seen_r;
    req_nxt.wr = wr_act && !wr_seen_r;
    dout_nxt = dout_r;
    doe_nxt = '0;
    // no acknowledge cycle: only plain reads drive data
    if (rd_act && !dma_req.own) begin
      // drive only the lanes that supply data
      if (!width_s) begin
        dout_nxt = {8'h00, a0_s ? reg_rdata[15:8] : reg_rdata[7:0]};
        doe_nxt = 16'h00ff;
      end else begin
        dout_nxt = reg_rdata;
        doe_nxt = {{8{lane_hi}}, {8{lane_lo}}};
      end
    end
  end

  // Slave path registers
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rd_seen_r <= 1'b0;
      wr_seen_r <= 1'b0;
      req_r <= '0;
      dout_r <= DATA_RST;
      doe_r <= '0;
    end else if (clk_en) begin
      rd_seen_r <= rd_seen_nxt;
      wr_seen_r <= wr_seen_nxt;
      req_r <= req_nxt;
      dout_r <= dout_nxt;
      doe_r <= doe_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Master address path
  // ---------------------------------------------------------------
  logic [23:0] aout_r, aout_nxt;
  logic aoe_r, aoe_nxt, uoe_r, uoe_nxt, uout_r, uout_nxt;

  // Address, plus the upper strobe on the wide data-strobe bus only, while the DMA engine owns the bus and drives an address phase
  always_comb begin
    aout_nxt = aout_r;
    aoe_nxt = 1'b0; // released when not mastering
    uoe_nxt = 1'b0; // released when idle
    uout_nxt = 1'b1;
    if (dma_req.own && dma_req.drive) begin
      aout_nxt = dma_req.addr;
      aoe_nxt = 1'b1;
      if (width_s && style_s) begin
        uoe_nxt = 1'b1;
        uout_nxt = !dma_req.lane_hi;
      end
    end
  end

  // Master path registers
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      aout_r <= ADDR_RST;
      aoe_r <= 1'b0;
      uoe_r <= 1'b0;
      uout_r <= 1'b1;
    end else if (clk_en) begin
      aout_r <= aout_nxt;
      aoe_r <= aoe_nxt;
      uoe_r <= uoe_nxt;
      uout_r <= uout_nxt;
    end
  end

  assign reg_req = req_r;
  assign data_out = dout_r;
  assign data_oe = doe_r;
  assign addr_out = aout_r;
  assign addr_oe = aoe_r;
  assign upper_strobe_out = uout_r;
  assign upper_strobe_oe = uoe_r;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  a_data_only_read: assert property (
    |data_oe && $past(clk_en) |-> $past(rd_act))
    else $error("Data driven without a read");
  a_addr_follows_dma: assert property (
    clk_en && dma_req.own && dma_req.drive |=> addr_oe
    && addr_out == $past(dma_req.addr))
    else $error("DMA address not driven");
  a_addr_released: assert property (
    clk_en && !(dma_req.own && dma_req.drive) |=> !addr_oe)
    else $error("Address driven while not master");
  a_release_after: assert property (
    $fell(dma_req.own) && clk_en ##1 clk_en
    |-> ##1 !addr_oe && !upper_strobe_oe)
    else $error("Master outputs not released");
  a_decode_addr: assert property (
    reg_req.rd |-> reg_req.addr[7:1] == $past(addr_s[7:1]))
    else $error("Register address mismatch");
  a_low_bit_narrow: assert property (
    (reg_req.rd || reg_req.wr) && !$past(width_s)
    |-> reg_req.addr[0] == $past(a0_s))
    else $error("Low address bit wrong");
  a_word_even: assert property (
    reg_req.lane_lo && reg_req.lane_hi && (reg_req.rd || reg_req.wr)
    && $past(width_s) |-> !reg_req.addr[0])
    else $error("Word access at odd address");
  a_upper_low_only: assert property (
    upper_strobe_oe |-> addr_oe)
    else $error("Upper strobe driven outside DMA");
  a_one_pulse: assert property (reg_req.rd && clk_en |=> !reg_req.rd)
    else $error("Read pulse too long");
  a_hi_lane_enable: assert property (
    reg_req.rd && $past(width_s) && !$past(style_s)
    |-> reg_req.lane_hi == !$past(bhe_n_s))
    else $error("High lane mismatch");
  a_lo_lane_enable: assert property (
    reg_req.rd && $past(width_s) && !$past(style_s)
    |-> reg_req.lane_lo == !$past(ble_n_s))
    else $error("Low lane mismatch");

  c_read: cover property (reg_req.rd);
  c_write: cover property (reg_req.wr);
  c_dma: cover property (addr_oe ##1 !addr_oe);
  c_word: cover property (reg_req.wr && reg_req.lane_lo && reg_req.lane_hi);
endmodule : demux_host_bus_port

// file: dv/host_model.sv
`timescale 1ns/1ps
// ---------------------------------------------------------------
// Host processor on the far side of the port
// ---------------------------------------------------------------
module host_model (
  input wire logic mclk,
  input wire logic style, // Bus style pin, static per run
  input wire logic width, // Bus width pin, static per run
  input wire logic [15:0] bus, // Resolved data lines
  output logic chip_sel_n,
  output logic rd_n,
  output logic wr_n,
  output logic rw,
  output logic ds_n,
  output logic [23:0] addr,
  output logic lowest_address_line,
  output logic low_byte_enable,
  output logic high_byte_enable,
  output logic lower_byte_strobe,
  output logic upper_byte_strobe,
  output logic [15:0] host_d // Host drive, a pattern once released
);
  // Idle pins: nothing selected, all strobes inactive
  task automatic idle();
    {chip_sel_n, rd_n, wr_n, ds_n, rw} = 5'h1f;
    {low_byte_enable, high_byte_enable} = 2'b11;
    {lower_byte_strobe, upper_byte_strobe} = 2'b11;
  endtask : idle

  initial begin
    idle();
    addr = 24'h000000;
    lowest_address_line = 1'b0;
    host_d = 16'h0000;
  end

  // One slave access; ln is {high, low} lane
  task automatic access(input logic wr, input logic [7:0] a,
      input logic [1:0] ln, input logic [15:0] d, input logic cs,
      output logic [15:0] rdata);
    @(negedge mclk);
    addr = {16'($urandom), a};
    lowest_address_line = a[0];
    rw = ~wr;
    host_d = wr ? d : ~host_d;
    chip_sel_n = ~cs;
    if (!style) begin
      if (width) {high_byte_enable, low_byte_enable} = ~ln;
      if (wr) wr_n = 1'b0;
      else rd_n = 1'b0;
    end else if (!width) ds_n = 1'b0;
    else {upper_byte_strobe, lower_byte_strobe} = ~ln;
    // Hold past the two sync flops and the register stage
    repeat (6) @(negedge mclk);
    rdata = bus;
    idle();
    // Released lines must not show the old value
    host_d = ~host_d;
    // Strobe stays inactive three cycles or more between accesses
    repeat (4) @(negedge mclk);
  endtask : access
endmodule : host_model

// file: dv/demux_host_bus_port_bench.sv
`timescale 1ns/1ps
`define CHK(got, exp) begin \
  num_checks++; \
  if ((got) !== (exp)) begin \
    mismatches++; \
    $display("CHECK FAILED %0t: got %h exp %h", $time, got, exp); \
  end \
end
// ---------------------------------------------------------------
// Bench: host model, register file stub, DMA driver
// ---------------------------------------------------------------
module demux_host_bus_port_bench import hostport_pkg::*;;
  logic mclk, rst_n, sty, wid, chip_sel_n, rd_n, wr_n, rw, ds_n, a0;
  logic clk_en; // Enable, dropped in each of the four DMA phases to prove the freeze
  logic [1:0] lanes; // Lane pattern of one access
  logic low_byte_enable, high_byte_enable;
  logic lower_byte_strobe, upper_byte_strobe;
  logic addr_oe, upper_strobe_out, upper_strobe_oe;
  logic [23:0] haddr, addr_out;
  logic [15:0] host_d, data_in, data_out, data_oe, reg_rdata, rdata;
  reg_req_t reg_req;
  dma_req_t dma_req;
  reg_req_t expq[$]; // Expected register requests in order
  int mismatches, num_checks;

  // Register file stub: contents derived from the address
  function automatic logic [15:0] rf(input logic [7:0] a);
    return {~a, a ^ 8'h3c};
  endfunction : rf
  assign reg_rdata = rf(reg_req.addr);
  // Wire level: device where enabled, host elsewhere
  assign data_in = (data_oe & data_out) | (~data_oe & host_d);

  demux_host_bus_port u_dut (.mclk, .rst_n, .clk_en, .chip_sel_n,
    .bus_style_select(sty), .bus_width(wid), .rd_n_in(rd_n),
    .wr_n_in(wr_n), .rw_in(rw), .ds_n_in(ds_n), .addr_in(haddr),
    .lowest_address_line(a0), .low_byte_enable, .high_byte_enable,
    .upper_byte_strobe, .lower_byte_strobe, .data_in, .data_out,
    .data_oe, .addr_out, .addr_oe, .upper_strobe_out, .upper_strobe_oe,
    .reg_req, .reg_rdata, .dma_req);
  host_model u_host (.mclk, .style(sty), .width(wid), .bus(data_in),
    .chip_sel_n, .rd_n, .wr_n, .rw, .ds_n, .addr(haddr),
    .lowest_address_line(a0), .low_byte_enable, .high_byte_enable,
    .lower_byte_strobe, .upper_byte_strobe, .host_d);

  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  // Each request pulse must match the oldest expectation
  always @(negedge mclk) begin
    reg_req_t e;
    logic [15:0] lm;
    if (reg_req.rd === 1'b1 || reg_req.wr === 1'b1) begin
      if (expq.size() == 0) `CHK(1'b1, 1'b0)
      else begin
        e = expq.pop_front();
        // Only lanes in use carry meaningful write data
        lm = wid ? {{8{e.lane_hi}}, {8{e.lane_lo}}} : 16'hffff;
        `CHK({reg_req.rd, reg_req.wr}, {e.rd, e.wr})
        `CHK(reg_req.addr, e.addr)
        if (e.wr) `CHK(reg_req.wdata & lm, e.wdata & lm)
        if (wid) `CHK(reg_req.lane_hi, e.lane_hi)
        if (wid) `CHK(reg_req.lane_lo, e.lane_lo)
      end
    end
  end

  task automatic run(input logic wr, input logic [7:0] a,
      input logic [1:0] ln, input logic [15:0] d, input logic cs);
    reg_req_t e;
    logic [15:0] m, r;
    e = '{rd: ~wr, wr: wr, addr: wid ? {a[7:1], ln == 2'b10} : a,
      lane_lo: ln[0], lane_hi: ln[1], wdata: wid ? d : {d[7:0], d[7:0]}};
    m = wid ? {{8{ln[1]}}, {8{ln[0]}}} : 16'h00ff;
    r = rf(e.addr);
    if (!wid) r = a[0] ? {8'h00, r[15:8]} : {8'h00, r[7:0]};
    if (cs) expq.push_back(e);
    u_host.access(wr, a, ln, d, cs, rdata);
    if (cs && !wr) `CHK(rdata & m, r & m)
    // Undriven lanes still show the host's own pattern
    if (!cs || wr) m = 16'h0000;
    `CHK(rdata & ~m, ~host_d & ~m)
    `CHK({data_oe, addr_oe}, 17'h00000)
  endtask : run

  // DMA address phase, then release
  task automatic dma(input logic [23:0] a, input logic hi);
    @(negedge mclk);
    dma_req = '{own: 1'b1, drive: 1'b1, addr: a, lane_lo: 1'b1, lane_hi: hi};
    @(negedge mclk);
    `CHK({addr_oe, addr_out}, {1'b1, a})
    `CHK(upper_strobe_oe, sty & wid)
    if (sty & wid) `CHK(upper_strobe_out, ~hi)
    // Enable low freezes the phase although the request drops
    clk_en = 1'b0;
    dma_req.drive = 1'b0;
    repeat (2) @(negedge mclk);
    `CHK({addr_oe, addr_out}, {1'b1, a})
    clk_en = 1'b1;
    @(negedge mclk);
    // Owner without an address phase keeps the lines released
    `CHK({addr_oe, upper_strobe_oe}, 2'b00)
    dma_req = '0;
    @(negedge mclk);
    `CHK({addr_oe, upper_strobe_oe}, 2'b00)
  endtask : dma

  task final_report;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : final_report

  // Watchdog, far beyond the expected run of about 615 cycles
  initial begin
    #1_000_000;
    mismatches++;
    final_report;
  end

  initial begin
    void'($urandom(32'hff71));
    {rst_n, sty, wid} = 3'b000;
    clk_en = 1'b1;
    dma_req = '0;
    repeat (3) @(negedge mclk);
    rst_n = 1'b1;
    `CHK({data_oe, addr_oe}, 17'h00000)
    `CHK({upper_strobe_oe, upper_strobe_out}, 2'b01)
    for (int s = 0; s < 4; s++) begin
      {sty, wid} = s[1:0];
      repeat (4) @(negedge mclk);
      for (int i = 0; i < 12; i++) begin
        // First three walk every lane pattern, the rest are random
        lanes = i < 3 ? 2'(i + 1) : 2'($urandom_range(3, 1));
        run(i[0], 8'($urandom), lanes, 16'($urandom), 1'b1);
      end
      run(1'b0, 8'h10, 2'b11, 16'h0000, 1'b0);
      dma(24'($urandom), 1'($urandom));
    end
    `CHK(expq.size(), 0)
    final_report;
  end
endmodule : demux_host_bus_port_bench
